// >>> core/retry_mon_pkg.sv
// Package with the constants, register map and carriers of the link retry attempt monitor.
// Contract
// R1: Warm reset clears the retry attempt counter to zero.
// R2: A retry started by CRC or protocol error increments the counter.
// R3: A failed reconnection followed by another retry increments the counter again.
// R4: Counter exceeding the allowed attempts limit declares an unrecoverable link error.
// R5: Valid NOPs after reinitialization clear the retry attempt counter.
// R6: Counter saturates at 8; afterwards no further unrecoverable errors are logged.
// R7: Retries never change link width or frequency.
// R8: Unrecoverable error sets link error flag bit 0; retries continue.
// R9: Flood, fatal, nonfatal enables follow check failures or unrecoverable errors by mode.
// R10: A newly set error flag floods or interrupts per the enables at that moment.
// R11: Force error in replay mode makes the transmitter send corrupted, not inverted, checks.
// R12: Entering the retry state sets the replay event log bit.
// R13: Replay fatal enable set when log bit sets raises a fatal interrupt.
// R14: Replay nonfatal enable set when log bit sets raises a nonfatal interrupt.
// R15: Replay statistics counter counts retries and training timeouts; writing zero clears it.
// R16: Strict init checking and protected info packets catch stuck or shorted lines.
// R17: A timer ends a stalled reinitialization as a failed attempt.
// R18: Reconnect trains, exchanges NOPs with ack count and credits, then replays history.
// R19: Replay mode is entered or left at warm reset according to its enable.
// R20: Training timer length is a parameter; statistics counter saturates at its maximum.
package retry_mon_pkg;
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_STATUS    = 8'h04;
   localparam logic [7:0] ADDR_COUNT     = 8'h08;
   localparam logic [7:0] ADDR_LINK      = 8'h0C;
   // Control register fields.
   localparam int CTRL_REPLAY_EN  = 0;
   localparam int CTRL_FLOOD_EN   = 1;
   localparam int CTRL_FATAL_EN   = 2;
   localparam int CTRL_NONFATAL_EN = 3;
   localparam int CTRL_FORCE_ERR  = 4;
   localparam int CTRL_RFATAL_EN  = 5;
   localparam int CTRL_RNONFAT_EN = 6;
   localparam int CTRL_LIMIT_LSB  = 8;
   localparam int LIMIT_W         = 4;
   localparam int CTRL_WIDTH_LSB  = 16;
   localparam int CTRL_FREQ_LSB   = 20;
   localparam int LINKCFG_W       = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0300;
   // Status register fields: write one to clear the log bits.
   localparam int ST_ERR_FLAG   = 0;
   localparam int ST_REPLAY_LOG = 1;
   localparam int ST_MODE       = 2;
   localparam int ST_CNT_LSB    = 4;
   localparam int ATT_W         = 4;
   localparam logic [ATT_W-1:0] ATT_SAT = 4'h8;
   localparam int STAT_W        = 16;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Training supervision time.
   localparam int TRAIN_TIMEOUT_US = 200;
   localparam int CLK_MHZ          = 20;
   localparam int TRAIN_CYCLES     = TRAIN_TIMEOUT_US * CLK_MHZ;

   typedef struct packed {
      logic flood;
      logic fatal;
      logic nonfatal;
   } err_resp_t;

   typedef struct packed {
      logic [LINKCFG_W-1:0] width;
      logic [LINKCFG_W-1:0] freq;
   } link_cfg_t;
endpackage : retry_mon_pkg

// >>> core/link_retry_attempt_monitor.sv
// Retry attempt tracking, unrecoverable error reporting and replay statistics for one link.
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module link_retry_attempt_monitor
   import retry_mon_pkg::*;
#(
   parameter int TRAIN_CYCLES_P = TRAIN_CYCLES
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        clk_en,
   input  wire logic        link_clk,
   input  wire logic        crc_error,
   input  wire logic        protocol_error,
   input  wire logic        periodic_check_fail,
   input  wire logic        reconnect_failed,
   input  wire logic        training_done,
   input  wire logic        init_seq_error,
   input  wire logic        valid_nops_rx,
   input  wire logic        link_stop_signal,
   input  wire logic [7:0]  receive_packet_ack_count,
   output logic             retry_start,
   output logic             retrying,
   output logic             replay_mode,
   output logic             corrupt_check_tx,
   output err_resp_t        err_resp,
   output link_cfg_t        link_cfg,
   output logic [7:0]       replay_from,
   output logic             link_clk_rise,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   typedef enum logic [1:0] {ST_UP, ST_TRAIN, ST_WAIT_NOP} link_state_t;

   link_state_t       state_q;
   logic [31:0]       ctrl_q = CTRL_RESET;
   logic [ATT_W-1:0]  retry_attempt_counter;
   logic [STAT_W-1:0] stat_q;
   logic [31:0]       timer_q;
   logic              err_flag_q;
   logic              replay_log_q;
   logic              mode_q;
   link_cfg_t         cfg_q;
   logic [2:0]        lclk_q;
   logic              aw_q, w_q;
   logic [7:0]        awaddr_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic              timeout;
   logic              error_in;
   logic              retry_again;
   logic              unrecov;
   logic              set_err;
   logic              wr_go;
   logic [ATT_W-1:0]  allowed_attempts_limit;

   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction : merge

   assign allowed_attempts_limit = ctrl_q[CTRL_LIMIT_LSB +: LIMIT_W];
   assign error_in    = crc_error | protocol_error;
   assign timeout     = (state_q == ST_TRAIN) && (timer_q >= TRAIN_CYCLES_P - 1);
   // A failed reconnect is a reported failure, a strict init check miss or a training timeout.
   assign retry_again = (state_q != ST_UP) && (reconnect_failed | init_seq_error | timeout); // R3 R16 R17
   assign retry_start = mode_q && ((state_q == ST_UP && error_in) || retry_again); // R2
   assign unrecov     = retry_start && retry_attempt_counter != ATT_SAT
                        && (retry_attempt_counter + 4'h1) > allowed_attempts_limit; // R4 R6
   assign set_err     = mode_q ? unrecov : periodic_check_fail; // R9
   assign retrying    = state_q != ST_UP;
   assign replay_mode = mode_q;
   assign corrupt_check_tx = mode_q & ctrl_q[CTRL_FORCE_ERR]; // R11
   assign link_cfg    = cfg_q;
   assign link_clk_rise = lclk_q[1] & lclk_q[2] & ~lclk_prev_q;

   // The link clock is sampled; its rising edge is seen when the second and third stage agree high.
   logic lclk_prev_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lclk_q      <= 3'h0;
         lclk_prev_q <= 1'b0;
      end else if (clk_en) begin
         lclk_q <= {lclk_q[1:0], link_clk};
         if (lclk_q[1] == lclk_q[2]) begin
            lclk_prev_q <= lclk_q[2];
         end
      end
   end

   // Mode is taken only at warm reset release; link configuration at warm reset release or a stop-signal disconnect.
   logic rst_seen_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_q     <= 1'b0;
         cfg_q      <= '0;
         rst_seen_q <= 1'b0;
      end else if (clk_en) begin
         rst_seen_q <= 1'b1;
         if (!rst_seen_q) begin
            mode_q <= ctrl_q[CTRL_REPLAY_EN]; // R19
            cfg_q  <= {ctrl_q[CTRL_WIDTH_LSB +: LINKCFG_W], ctrl_q[CTRL_FREQ_LSB +: LINKCFG_W]}; // R7
         end else if (link_stop_signal) begin
            cfg_q  <= {ctrl_q[CTRL_WIDTH_LSB +: LINKCFG_W], ctrl_q[CTRL_FREQ_LSB +: LINKCFG_W]}; // R7
         end
      end
   end

   // Reconnect sequence: train, exchange NOPs, then replay from one past the acknowledged count.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q     <= ST_UP;
         timer_q     <= '0;
         replay_from <= 8'h00;
      end else if (clk_en) begin
         case (state_q)
            ST_UP: begin
               timer_q <= '0;
               if (retry_start) begin
                  state_q <= ST_TRAIN;
               end
            end
            ST_TRAIN: begin
               timer_q <= timer_q + 32'h1; // R17
               if (retry_again) begin
                  timer_q <= '0;
               end else if (training_done) begin
                  state_q <= ST_WAIT_NOP; // R18
               end
            end
            ST_WAIT_NOP: begin
               // Each new attempt gets a full training budget of its own.
               timer_q <= '0; // R17
               if (retry_again) begin
                  state_q <= ST_TRAIN;
               end else if (valid_nops_rx) begin
                  state_q     <= ST_UP;
                  replay_from <= receive_packet_ack_count + 8'h01; // R18
               end
            end
            default: state_q <= ST_UP;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         retry_attempt_counter <= '0; // R1
      end else if (clk_en) begin
         if (retry_start && retry_attempt_counter != ATT_SAT) begin
            retry_attempt_counter <= retry_attempt_counter + 4'h1; // R2 R3 R6
         end else if (state_q == ST_WAIT_NOP && valid_nops_rx && !retry_again) begin
            retry_attempt_counter <= '0; // R5
         end
      end
   end

   // Responses fire on the cycle a flag becomes set, using the enables of that cycle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         err_resp <= '0;
      end else if (clk_en) begin
         err_resp.flood    <= set_err & ~err_flag_q & ctrl_q[CTRL_FLOOD_EN]; // R10
         err_resp.fatal    <= (set_err & ~err_flag_q & ctrl_q[CTRL_FATAL_EN])
                              | (retry_start & ~replay_log_q & ctrl_q[CTRL_RFATAL_EN]); // R13
         err_resp.nonfatal <= (set_err & ~err_flag_q & ctrl_q[CTRL_NONFATAL_EN])
                              | (retry_start & ~replay_log_q & ctrl_q[CTRL_RNONFAT_EN]); // R14
      end
   end

   // Write channel capture: address and data may arrive in either order.
   assign s_axi_awready = !aw_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_q && !s_axi_bvalid;
   assign wr_go         = aw_q && w_q && !s_axi_bvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q         <= 1'b0;
         w_q          <= 1'b0;
         awaddr_q     <= 8'h00;
         wdata_q      <= 32'h0000_0000;
         wstrb_q      <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q     <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q     <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_q         <= 1'b0;
            w_q          <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_q == ADDR_CTRL || awaddr_q == ADDR_STATUS
                             || awaddr_q == ADDR_COUNT) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      // Control keeps its value through warm reset so that a replay enable or link setting written
      // beforehand takes effect at release; the declaration holds the power-up value.
      if (aresetn && clk_en && wr_go && awaddr_q == ADDR_CTRL) begin
         ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
      end
   end

   // Log bits: hardware set wins over a software write-one clear.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         err_flag_q   <= 1'b0;
         replay_log_q <= 1'b0;
      end else if (clk_en) begin
         if (set_err) begin
            err_flag_q <= 1'b1; // R8
         end else if (wr_go && awaddr_q == ADDR_STATUS && wstrb_q[0] && wdata_q[ST_ERR_FLAG]) begin
            err_flag_q <= 1'b0;
         end
         if (retry_start) begin
            replay_log_q <= 1'b1; // R12
         end else if (wr_go && awaddr_q == ADDR_STATUS && wstrb_q[0] && wdata_q[ST_REPLAY_LOG]) begin
            replay_log_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_q <= '0;
      end else if (clk_en) begin
         if ((retry_start || timeout) && stat_q != {STAT_W{1'b1}}) begin
            stat_q <= stat_q + 16'h0001; // R15 R20
         end else if (wr_go && awaddr_q == ADDR_COUNT && wdata_q[STAT_W-1:0] == 16'h0000) begin
            stat_q <= '0; // R15
         end
      end
   end

   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            case (s_axi_araddr)
               ADDR_CTRL:   s_axi_rdata <= ctrl_q;
               ADDR_STATUS: s_axi_rdata <= {24'h000000, retry_attempt_counter,
                                            1'b0, mode_q, replay_log_q, err_flag_q};
               ADDR_COUNT:  s_axi_rdata <= {16'h0000, stat_q};
               ADDR_LINK:   s_axi_rdata <= {24'h000000, cfg_q};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   a_count_step: assert property (@(posedge aclk) disable iff (!aresetn) // R2
      clk_en && retry_start && retry_attempt_counter != ATT_SAT
      |=> retry_attempt_counter == $past(retry_attempt_counter) + 4'h1)
      else $error("retry counter did not step");
   a_count_sat: assert property (@(posedge aclk) disable iff (!aresetn) // R6
      retry_attempt_counter <= ATT_SAT) else $error("retry counter above eight");
   a_unrecov_flag: assert property (@(posedge aclk) disable iff (!aresetn) // R8
      clk_en && mode_q && unrecov |=> err_flag_q) else $error("error flag not set");
   a_replay_log: assert property (@(posedge aclk) disable iff (!aresetn) // R12
      clk_en && retry_start |=> replay_log_q && state_q == ST_TRAIN) else $error("log bit missing");
   a_fatal_irq: assert property (@(posedge aclk) disable iff (!aresetn) // R13
      clk_en && retry_start && !replay_log_q && ctrl_q[CTRL_RFATAL_EN] |=> err_resp.fatal)
      else $error("fatal interrupt missing");
   a_nopclear: assert property (@(posedge aclk) disable iff (!aresetn) // R5
      clk_en && state_q == ST_WAIT_NOP && valid_nops_rx && !retry_again
      |=> retry_attempt_counter == 4'h0 && state_q == ST_UP) else $error("counter not cleared");
   a_cfg_hold: assert property (@(posedge aclk) disable iff (!aresetn) // R7
      rst_seen_q && !link_stop_signal |=> $stable(cfg_q)) else $error("link config changed");
   a_stat_sat: assert property (@(posedge aclk) disable iff (!aresetn) // R20
      stat_q == {STAT_W{1'b1}} && !wr_go |=> stat_q == {STAT_W{1'b1}}) else $error("stat wrapped");
endmodule : link_retry_attempt_monitor

// >>> dv/peer_link_model.sv
// Behavioural peer link end that answers retries with training and NOPs, a failure or a stall.
`timescale 1ns/1ps
module peer_link_model (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       retry_start,
   input  wire logic [3:0] fails,
   input  wire logic       slow,
   output logic            training_done,
   output logic            reconnect_failed,
   output logic            init_seq_error,
   output logic            valid_nops_rx,
   output logic [7:0]      receive_packet_ack_count,
   output logic            link_clk
);
   logic [5:0] phase_q;
   logic [3:0] failed_q;
   initial begin
      link_clk = 1'b0;
      forever #200 link_clk = ~link_clk;
   end
   assign receive_packet_ack_count = 8'h41;
   always_ff @(posedge aclk) begin
      training_done <= 1'b0;
      reconnect_failed <= 1'b0;
      init_seq_error <= 1'b0;
      valid_nops_rx <= 1'b0;
      if (!aresetn) begin
         phase_q <= 6'h00;
         failed_q <= 4'h0;
      end else if (retry_start) begin
         phase_q <= 6'h01;
      end else if (phase_q != 6'h00) begin
         phase_q <= phase_q + 6'h01;
         // A slow peer never finishes training, so the attempt must end by the timer.
         if (phase_q == 6'h04 && !slow) training_done <= 1'b1;
         if (phase_q == 6'h08 && !slow) begin
            phase_q <= 6'h00;
            if (failed_q < fails) begin
               failed_q <= failed_q + 4'h1;
               if (failed_q[0]) init_seq_error <= 1'b1;
               else reconnect_failed <= 1'b1;
            end else begin
               failed_q <= 4'h0;
               valid_nops_rx <= 1'b1;
            end
         end
      end
   end
endmodule : peer_link_model

// >>> dv/link_retry_attempt_monitor_tb.sv
// Self-checking bench for the link retry attempt monitor.
`timescale 1ns/1ps
module link_retry_attempt_monitor_tb;
   import retry_mon_pkg::*;
   typedef struct packed {
      logic [31:0] ctrl;
      logic        proto;
      logic [3:0]  fails;
      logic [1:0]  fatal;
      logic [1:0]  nonfatal;
      logic [1:0]  flood;
   } row_t;
   localparam row_t ROWS [5] = '{
      row_t'{32'h0000_0329, 1'b0, 4'h0, 2'h1, 2'h0, 2'h0},
      row_t'{32'h0000_0129, 1'b1, 4'h3, 2'h1, 2'h1, 2'h0},
      row_t'{32'h0000_0743, 1'b0, 4'hA, 2'h0, 2'h1, 2'h1},
      row_t'{32'h0000_0843, 1'b0, 4'hA, 2'h0, 2'h1, 2'h0},
      row_t'{32'h0000_0245, 1'b1, 4'h2, 2'h1, 2'h1, 2'h0}};
   logic aclk, aresetn, clk_en, link_clk, crc_error, protocol_error, periodic_check_fail;
   logic reconnect_failed, training_done, init_seq_error, valid_nops_rx, link_stop_signal;
   logic [7:0] receive_packet_ack_count, replay_from, s_axi_awaddr, s_axi_araddr;
   logic retry_start, retrying, replay_mode, corrupt_check_tx, link_clk_rise, slow;
   err_resp_t err_resp;
   link_cfg_t link_cfg;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb, fails;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [4:0] att;
   int bad_count, compares, cycles, n_fatal, n_nonfatal, n_flood, n_rise;
   row_t r;

   link_retry_attempt_monitor #(.TRAIN_CYCLES_P(20)) i_dut (
      .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .link_clk(link_clk), .crc_error(crc_error),
      .protocol_error(protocol_error), .periodic_check_fail(periodic_check_fail),
      .reconnect_failed(reconnect_failed), .training_done(training_done), .init_seq_error(init_seq_error),
      .valid_nops_rx(valid_nops_rx), .link_stop_signal(link_stop_signal),
      .receive_packet_ack_count(receive_packet_ack_count), .retry_start(retry_start), .retrying(retrying),
      .replay_mode(replay_mode), .corrupt_check_tx(corrupt_check_tx), .err_resp(err_resp),
      .link_cfg(link_cfg), .replay_from(replay_from), .link_clk_rise(link_clk_rise),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

   peer_link_model i_peer (
      .aclk(aclk), .aresetn(aresetn), .retry_start(retry_start), .fails(fails), .slow(slow),
      .training_done(training_done), .reconnect_failed(reconnect_failed), .init_seq_error(init_seq_error),
      .valid_nops_rx(valid_nops_rx), .receive_packet_ack_count(receive_packet_ack_count),
      .link_clk(link_clk));

   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   always @(posedge aclk) begin
      if (err_resp.fatal === 1'b1) n_fatal = n_fatal + 1;
      if (err_resp.nonfatal === 1'b1) n_nonfatal = n_nonfatal + 1;
      if (err_resp.flood === 1'b1) n_flood = n_flood + 1;
      cycles = cycles + 1;
      if (cycles == 20000) begin
         bad_count = bad_count + 1;
         give_verdict();
      end
   end

   task automatic give_verdict();
      if (bad_count == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : give_verdict

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares = compares + 1;
      if (seen !== exp) begin
         bad_count = bad_count + 1;
         $display("wrong value %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check

   task automatic axi_write(input logic [7:0] a, input logic [31:0] w);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= w;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_read

   task automatic do_reset();
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
   endtask : do_reset

   task automatic pulse(input int which);
      @(posedge aclk);
      crc_error <= (which == 0);
      protocol_error <= (which == 1);
      periodic_check_fail <= (which == 2);
      @(posedge aclk);
      crc_error <= 1'b0;
      protocol_error <= 1'b0;
      periodic_check_fail <= 1'b0;
   endtask : pulse

   initial begin
      {aresetn, crc_error, protocol_error, periodic_check_fail, link_stop_signal, slow} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, fails} = '0;
      clk_en = 1'b1;
      s_axi_wstrb = 4'hF;
      bad_count = 0;
      compares = 0;
      cycles = 0;
      do_reset();
      axi_read(ADDR_CTRL);
      check("control reset", d, CTRL_RESET);
      axi_read(ADDR_STATUS);
      check("status reset", d, 32'h0000_0000);
      axi_read(8'h10);
      check("unmapped read", {resp, d[29:0]}, {RESP_SLVERR, 30'h0});
      axi_write(ADDR_CTRL, 32'h0035_0001);
      do_reset();
      repeat (2) @(posedge aclk);
      check("mode after reset", replay_mode, 1'b1);
      check("link cfg after reset", link_cfg, 8'h53);
      pulse(2);
      axi_read(ADDR_STATUS);
      check("check fail in replay mode", d[2:0], 3'h4);
      for (int i = 0; i < 5; i++) begin
         r = ROWS[i];
         axi_write(ADDR_CTRL, r.ctrl);
         axi_write(ADDR_STATUS, 32'h0000_0003);
         axi_write(ADDR_COUNT, 32'h0000_0000);
         check("count clear response", resp, RESP_OKAY);
         fails <= r.fails;
         n_fatal = 0;
         n_nonfatal = 0;
         n_flood = 0;
         pulse(r.proto ? 1 : 0);
         for (int n = 0; n < 400 && (n < 3 || retrying !== 1'b0); n++) @(posedge aclk);
         att = (r.fails > 4'h7) ? 5'h08 : {1'b0, r.fails} + 5'h01;
         axi_read(ADDR_STATUS);
         check("unrecoverable flag", d[0], {1'b0, r.ctrl[11:8]} < att);
         check("replay log", d[1], 1'b1);
         check("attempts after nops", d[7:4], 4'h0);
         axi_read(ADDR_COUNT);
         check("statistics", d, {28'h0, r.fails} + 32'h1);
         check("fatal pulses", n_fatal, r.fatal);
         check("nonfatal pulses", n_nonfatal, r.nonfatal);
         check("flood pulses", n_flood, r.flood);
         check("replay start", replay_from, 8'h42);
      end
      check("link cfg after retries", link_cfg, 8'h53);
      axi_write(ADDR_LINK, 32'h0000_00FF);
      check("write to read-only", resp, RESP_SLVERR);
      check("link cfg kept", link_cfg, 8'h53);
      axi_write(ADDR_CTRL, 32'h0000_0011);
      check("corrupt check", corrupt_check_tx, 1'b1);
      slow <= 1'b1;
      pulse(0);
      n_rise = 0;
      repeat (80) begin
         @(posedge aclk);
         if (link_clk_rise === 1'b1) n_rise = n_rise + 1;
      end
      check("link clock edges", n_rise, 10);
      check("still retrying", retrying, 1'b1);
      axi_read(ADDR_STATUS);
      check("stalled attempts", d[7:4] > 4'h1, 1'b1);
      do_reset();
      slow <= 1'b0;
      axi_read(ADDR_STATUS);
      check("attempts after reset", d[7:4], 4'h0);
      check("link cfg reloaded", link_cfg, 8'h00);
      axi_write(ADDR_CTRL, 32'h0000_0014);
      do_reset();
      repeat (2) @(posedge aclk);
      check("mode off", replay_mode, 1'b0);
      check("corrupt off", corrupt_check_tx, 1'b0);
      n_fatal = 0;
      pulse(2);
      repeat (3) @(posedge aclk);
      axi_read(ADDR_STATUS);
      check("check fail flag", d[0], 1'b1);
      check("check fail fatal", n_fatal, 1);
      axi_write(ADDR_STATUS, 32'h0000_0001);
      clk_en <= 1'b0;
      pulse(2);
      clk_en <= 1'b1;
      axi_read(ADDR_STATUS);
      check("frozen check fail", d[0], 1'b0);
      give_verdict();
   end
endmodule : link_retry_attempt_monitor_tb
